// *** ivl_pkg.sv ***
// constants and helpers shared by the interrupt vectoring and low-voltage block
package ivl_pkg;
    localparam int unsigned AW   = 4;
    localparam int unsigned DW   = 8;
    localparam int unsigned NVEC = 32;
    localparam int unsigned VW   = 5;

    // register offsets
    localparam logic [AW-1:0] A_PIN = 4'h0;
    localparam logic [AW-1:0] A_PMC = 4'h1;
    localparam logic [AW-1:0] A_RST = 4'h2;
    localparam logic [AW-1:0] A_EN0 = 4'h3;
    localparam logic [AW-1:0] A_VEC = 4'h7;

    // pin control fields
    localparam int unsigned B_MODE = 0;
    localparam int unsigned B_IE   = 1;
    localparam int unsigned B_ACK  = 2;
    localparam int unsigned B_FLAG = 3;
    localparam int unsigned B_PE   = 4;
    localparam int unsigned B_POL  = 5;

    // power management control fields
    localparam int unsigned B_LVTH  = 0;
    localparam int unsigned B_DETEN = 2;
    localparam int unsigned B_LVSE  = 3;
    localparam int unsigned B_LVRE  = 4;
    localparam int unsigned B_WRNIE = 5;
    localparam int unsigned B_LVWAK = 6;
    localparam int unsigned B_WRNFL = 7;

    // reset status fields
    localparam int unsigned S_POR  = 7;
    localparam int unsigned S_PIN  = 6;
    localparam int unsigned S_WDT  = 5;
    localparam int unsigned S_ILOP = 4;
    localparam int unsigned S_ILAD = 3;
    localparam int unsigned S_LVD  = 1;

    // values after reset
    localparam logic [DW-1:0] PIN_RST = 8'h00;
    localparam logic [DW-1:0] PMC_RST = 8'h1C;
    localparam logic [DW-1:0] STS_POR = 8'h82;
    localparam logic [31:0]   EN_RST  = 32'h0000_0000;

    // vector slots
    localparam logic [VW-1:0] V_RESET = 5'h00;
    localparam logic [VW-1:0] V_TRAP  = 5'h01;
    localparam logic [VW-1:0] V_PIN   = 5'h02;
    localparam logic [VW-1:0] V_WARN  = 5'h03;
    localparam logic [31:0]   USED    = 32'h47B7_F860;
    localparam logic [15:0]   VEC_TOP = 16'hFFFE;

    // address of the high byte; the low byte sits one above
    function automatic logic [15:0] vec_addr(input logic [VW-1:0] n);
        vec_addr = VEC_TOP - {10'h000, n, 1'b0};
    endfunction
endpackage

// *** ivl_if.sv ***
// carriers between the controller and its two sub-blocks
`timescale 1ns/1ps
interface ivl_pin_if;
    logic pin_lvl;
    logic pin_func_enable;
    logic pin_polarity_select;
    logic pin_detect_mode;
    logic pin_event_ack;
    logic pin_event_flag;
    modport ctrl (output pin_lvl, pin_func_enable, pin_polarity_select, pin_detect_mode,
                  output pin_event_ack, input pin_event_flag);
    modport det  (input pin_lvl, pin_func_enable, pin_polarity_select, pin_detect_mode,
                  input pin_event_ack, output pin_event_flag);
endinterface

interface ivl_pri_if;
    logic [31:0]   pending;
    logic          found;
    logic [4:0]    num;
    modport ctrl (output pending, input found, num);
    modport enc  (input pending, output found, num);
endinterface

// *** ivl_pin_det.sv ***
// pin event detector: edge-only or edge-and-level, selectable polarity
`timescale 1ns/1ps
module ivl_pin_det
    import ivl_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic soft_rst,
    ivl_pin_if.det    p
);
    logic asserted;
    logic prev_reg;
    logic flag_reg;
    logic flag_next;
    logic edge_seen;
    logic held;

    assign asserted  = p.pin_polarity_select ? p.pin_lvl : ~p.pin_lvl;
    assign edge_seen = asserted & ~prev_reg;
    assign held      = p.pin_detect_mode & asserted;
    // set beats a clear in the same cycle; an asserted pin in level mode blocks the clear
    assign flag_next = (p.pin_func_enable & (edge_seen | held))
                     | (flag_reg & ~(p.pin_event_ack & ~held));
    assign p.pin_event_flag = flag_reg;

    // prev starts asserted-high so an idle pin at release gives no false edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b1;
            flag_reg <= 1'b0;
        end else if (soft_rst) begin
            prev_reg <= 1'b1;
            flag_reg <= 1'b0;
        end else begin
            prev_reg <= asserted;
            flag_reg <= flag_next;
        end
    end
endmodule

// *** ivl_prio.sv ***
// fixed-priority encoder: lowest pending slot number wins
`timescale 1ns/1ps
module ivl_prio
    import ivl_pkg::*;
(
    ivl_pri_if.enc e
);
    function automatic logic [VW:0] first_set(input logic [31:0] v);
        logic [VW:0] r;
        r = '0;
        for (int i = NVEC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, i[VW-1:0]};
            end
        end
        return r;
    endfunction

    logic [VW:0] hit;
    assign hit     = first_set(e.pending);
    assign e.found = hit[VW];
    assign e.num   = hit[VW-1:0];
endmodule

// *** ivl_ctrl.sv ***
// interrupt vectoring, pin event and low-voltage detect controller
// Contract
// - in edge-and-level mode a deasserted-to-asserted pin transition sets the pin flag
// - in edge-and-level mode the flag stays set and uncleared while pin asserted
// - vectors are two bytes; high byte at lower address, low byte above
// - a source flag requests the CPU only while its local enable is 1
// - priority fixed by vector number; lower number always wins
// - 32 slots; pin uses 2, warning 3, software trap 1, rest unused; the code routes periph_flags into the slots set in USED
// - watchdog, low-voltage, reset pin, bad opcode, bad address share slot 0
// - low-voltage detection works only while its enable bit is 1
// - stop entry disables low-voltage detection unless stop enable is set
// - with detect and stop enable both set, deepest sleep is refused
// - power-on reset sets both power-on and low-voltage status flags
// - with reset enable 1, a low-voltage condition causes a system reset
// - threshold select chooses which comparator threshold is used
// - warning with warn interrupt enable sets warn flag and requests interrupt
// - low-voltage reset also sets the low-voltage status flag
// - after power-on or low-voltage reset, hold reset until supply above threshold
// - pin sets its flag only while the pin function enable is set
// - polarity 0 means falling/low active, 1 means rising/high active
// - writing 1 to acknowledge clears pin flag; 0 does nothing; reads 0
// - detect mode 0 is edge-only, 1 is edge-and-level
`timescale 1ns/1ps
module ivl_ctrl
    import ivl_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic [ivl_pkg::AW-1:0] addr,
    input  wire logic [ivl_pkg::DW-1:0] wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [ivl_pkg::DW-1:0] rdata,
    input  wire logic                   irq_pin,
    input  wire logic [31:0]            periph_flags,
    input  wire logic                   software_trap,
    input  wire logic                   lowv_below_lo,
    input  wire logic                   lowv_below_hi,
    input  wire logic                   lowv_warn_cond,
    input  wire logic                   ext_reset_n,
    input  wire logic                   watchdog_timeout,
    input  wire logic                   illegal_opcode,
    input  wire logic                   illegal_addr,
    input  wire logic                   cpu_in_stop,
    output logic                        deepest_sleep_allowed,
    output logic                        sys_reset,
    output logic                        cpu_irq_req,
    output logic      [ivl_pkg::VW-1:0] cpu_vec_num,
    output logic      [15:0]            cpu_vec_addr_hi,
    output logic      [15:0]            cpu_vec_addr_lo
);
    ivl_pin_if pif ();
    ivl_pri_if qif ();

    logic [1:0]    rst_sync;
    logic          rst_n;
    logic [1:0]    pin_s;
    logic [1:0]    lo_s;
    logic [1:0]    hi_s;
    logic [1:0]    warn_s;
    logic [1:0]    ext_s;
    logic [DW-1:0] pin_reg;
    logic [DW-1:0] pmc_reg;
    logic [DW-1:0] sts_reg;
    logic [DW-1:0] sts_next;
    logic [31:0]   en_reg;
    logic          hold_reg;
    logic          evt_reg;
    logic          wf_reg;
    logic          wf_next;
    logic [VW-1:0] vec_reg;
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] rd_mux;

    // reset release through two flops; everything else uses the copy
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // pin-side levels cross into the clock domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s  <= 2'b11;
            lo_s   <= 2'b11;
            hi_s   <= 2'b11;
            warn_s <= 2'b00;
            ext_s  <= 2'b11;
        end else begin
            pin_s  <= {pin_s[0], irq_pin};
            lo_s   <= {lo_s[0], lowv_below_lo};
            hi_s   <= {hi_s[0], lowv_below_hi};
            warn_s <= {warn_s[0], lowv_warn_cond};
            ext_s  <= {ext_s[0], ext_reset_n};
        end
    end

    // bus decode
    wire w_pin = wr && (addr == A_PIN);
    wire w_pmc = wr && (addr == A_PMC);
    wire [AW-1:0] en_idx = addr - A_EN0;
    wire w_en  = wr && (addr >= A_EN0) && (addr < A_EN0 + 4'h4);

    // low-voltage detect behaviour
    wire lv_de    = pmc_reg[B_DETEN];
    wire lv_se    = pmc_reg[B_LVSE];
    wire lv_on    = lv_de && (!cpu_in_stop || lv_se);
    wire below    = pmc_reg[B_LVTH] ? hi_s[1] : lo_s[1];
    wire lv_reset = lv_on && pmc_reg[B_LVRE] && below;
    wire warn_set = lv_on && pmc_reg[B_WRNIE] && warn_s[1];
    assign deepest_sleep_allowed = !(lv_de && lv_se);

    // reset sources all land on slot 0
    wire ev_pin  = !ext_s[1];
    wire any_evt = lv_reset || ev_pin || watchdog_timeout || illegal_opcode
                 || illegal_addr;
    assign sys_reset = hold_reg || evt_reg;

    always_comb begin
        sts_next = 8'h00;
        sts_next[S_PIN]  = ev_pin;
        sts_next[S_WDT]  = watchdog_timeout;
        sts_next[S_ILOP] = illegal_opcode;
        sts_next[S_ILAD] = illegal_addr;
        sts_next[S_LVD]  = lv_reset;
    end

    // the hold releases only when the selected comparator sees a good supply
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg <= 1'b1;
            evt_reg  <= 1'b0;
            sts_reg  <= STS_POR;
        end else begin
            evt_reg <= any_evt;
            if (lv_reset) begin
                hold_reg <= 1'b1;
            end else if (!below) begin
                hold_reg <= 1'b0;
            end
            // events inside a hold keep the cause that began it, so power-on stays
            // visible; a second cause during the hold is not recorded
            if (any_evt && !hold_reg) begin
                sts_reg <= sts_next;
            end
        end
    end

    // software registers; other resets clear them, status survives
    assign wf_next = warn_set || (wf_reg && !(w_pmc && wdata[B_LVWAK]));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_reg <= PIN_RST;
            pmc_reg <= PMC_RST;
            en_reg  <= EN_RST;
            wf_reg  <= 1'b0;
        end else if (sys_reset) begin
            pin_reg <= PIN_RST;
            pmc_reg <= PMC_RST;
            en_reg  <= EN_RST;
            wf_reg  <= 1'b0;
        end else begin
            wf_reg <= wf_next;
            if (w_pin) begin
                pin_reg <= wdata & 8'h33;
            end
            if (w_pmc) begin
                pmc_reg <= wdata & 8'h3D;
            end
            if (w_en) begin
                en_reg[en_idx[1:0]*8 +: 8] <= wdata;
            end
        end
    end

    // pin detector
    assign pif.pin_lvl             = pin_s[1];
    assign pif.pin_func_enable     = pin_reg[B_PE];
    assign pif.pin_polarity_select = pin_reg[B_POL];
    assign pif.pin_detect_mode     = pin_reg[B_MODE];
    assign pif.pin_event_ack       = w_pin && wdata[B_ACK];

    ivl_pin_det u_det (
        .clk      (clk),
        .rst_n    (rst_n),
        .soft_rst (sys_reset),
        .p        (pif)
    );

    // pending requests by slot
    always_comb begin
        qif.pending = periph_flags & en_reg & USED;
        qif.pending[V_RESET] = 1'b0;
        qif.pending[V_TRAP]  = software_trap;
        qif.pending[V_PIN]   = pif.pin_event_flag && pin_reg[B_IE];
        qif.pending[V_WARN]  = wf_reg && pmc_reg[B_WRNIE];
    end

    ivl_prio u_prio (
        .e (qif)
    );

    // the core's own stacking and masking sequence follows the request
    assign cpu_irq_req = qif.found && !sys_reset;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_reg <= V_RESET;
        end else if (sys_reset) begin
            vec_reg <= V_RESET;
        end else if (qif.found) begin
            vec_reg <= qif.num;
        end
    end
    assign cpu_vec_num     = vec_reg;
    assign cpu_vec_addr_hi = vec_addr(vec_reg);
    assign cpu_vec_addr_lo = vec_addr(vec_reg) + 16'h0001;

    // read data: acknowledge bits always read zero
    wire [DW-1:0] pin_rd = {pin_reg[7:4], pif.pin_event_flag, 1'b0, pin_reg[1:0]};
    wire [DW-1:0] pmc_rd = {wf_reg, 1'b0, pmc_reg[5:0]};
    wire [DW-1:0] vec_rd = {cpu_irq_req, 2'b00, vec_reg};
    wire [DW-1:0] en_rd  = en_reg[en_idx[1:0]*8 +: 8];
    assign rd_mux = (addr == A_PIN) ? pin_rd
                  : (addr == A_PMC) ? pmc_rd
                  : (addr == A_RST) ? sts_reg
                  : (addr >= A_EN0 && addr < A_EN0 + 4'h4) ? en_rd
                  : (addr == A_VEC) ? vec_rd
                  : 8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign rdata = rdata_reg;
endmodule

// *** ivl_ctrl_props.sv ***
// port-level checks for the interrupt vectoring and low-voltage controller
`timescale 1ns/1ps
module ivl_ctrl_props
    import ivl_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   rstn,
    input wire logic [ivl_pkg::AW-1:0] addr,
    input wire logic [ivl_pkg::DW-1:0] wdata,
    input wire logic                   wr,
    input wire logic                   rd,
    input wire logic [ivl_pkg::DW-1:0] rdata,
    input wire logic                   software_trap,
    input wire logic                   ext_reset_n,
    input wire logic                   watchdog_timeout,
    input wire logic                   deepest_sleep_allowed,
    input wire logic                   sys_reset,
    input wire logic                   cpu_irq_req,
    input wire logic [ivl_pkg::VW-1:0] cpu_vec_num,
    input wire logic [15:0]            cpu_vec_addr_hi,
    input wire logic [15:0]            cpu_vec_addr_lo
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ack_reads_zero: assert property (rd && addr == A_PIN
        |=> rdata[7:6] == 2'b00 && !rdata[B_ACK])
        else $error("pin control read shows ack or reserved bits");
    a_vec_bytes: assert property (cpu_vec_addr_hi == 16'hFFFE - {10'h000, cpu_vec_num, 1'b0}
        && cpu_vec_addr_lo == cpu_vec_addr_hi + 16'h0001)
        else $error("vector byte addresses wrong");
    a_no_req_reset: assert property (sys_reset |-> !cpu_irq_req)
        else $error("request raised during system reset");
    a_trap_wins: assert property ((software_trap && !sys_reset) [*3]
        |-> cpu_vec_num == V_TRAP)
        else $error("software trap lost priority");
    a_trap_req: assert property (software_trap && !sys_reset
        |-> ##[0:2] (cpu_irq_req || sys_reset))
        else $error("software trap gave no request");
    a_wdog_reset: assert property (watchdog_timeout && !sys_reset |=> sys_reset)
        else $error("watchdog event gave no reset");
    a_pin_reset: assert property ($fell(ext_reset_n) |-> ##[1:4] sys_reset)
        else $error("reset pin gave no reset");
    a_sleep_refuse: assert property (wr && addr == A_PMC && !sys_reset ##1 !sys_reset
        |-> deepest_sleep_allowed == !($past(wdata[B_DETEN]) && $past(wdata[B_LVSE])))
        else $error("deepest sleep permission wrong");
    a_reset_defaults: assert property ($fell(sys_reset) |-> !deepest_sleep_allowed)
        else $error("detect enables not set after reset");
    a_reset_vec: assert property (sys_reset [*2] |-> cpu_vec_num == V_RESET)
        else $error("vector not slot zero in reset");

    c_trap: cover property (software_trap && cpu_irq_req);
    c_reset: cover property ($rose(sys_reset));
    c_vec_read: cover property (rd && addr == A_VEC ##1 rdata[7]);
endmodule

bind ivl_ctrl ivl_ctrl_props u_props (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .software_trap(software_trap), .ext_reset_n(ext_reset_n),
    .watchdog_timeout(watchdog_timeout), .deepest_sleep_allowed(deepest_sleep_allowed),
    .sys_reset(sys_reset), .cpu_irq_req(cpu_irq_req), .cpu_vec_num(cpu_vec_num),
    .cpu_vec_addr_hi(cpu_vec_addr_hi), .cpu_vec_addr_lo(cpu_vec_addr_lo));

// *** ivl_cpu_model.sv ***
// core model: opens the global mask for one cycle and fetches the winning vector
`timescale 1ns/1ps
module ivl_cpu_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        cpu_irq_req,
    input  wire logic [15:0] cpu_vec_addr_hi,
    input  wire logic        mask_clr,
    output logic      [15:0] fetched
);
    logic mask_reg;
    // mask starts set; software clears it briefly, so one request is taken per window
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= 1'b1;
            fetched  <= 16'h0000;
        end else if (mask_clr) begin
            mask_reg <= 1'b0;
        end else begin
            mask_reg <= 1'b1;
            if (!mask_reg && cpu_irq_req) fetched <= cpu_vec_addr_hi;
        end
    end
endmodule

// *** test_interrupt_vectoring_and_lvd.sv ***
// self-checking bench for the interrupt vectoring and low-voltage controller
`timescale 1ns/1ps
module test_interrupt_vectoring_and_lvd;
    import ivl_pkg::*;
    logic        clk, rstn, wr, rd, irq_pin, software_trap, mask_clr;
    logic        lowv_below_lo, lowv_below_hi, lowv_warn_cond, ext_reset_n, cpu_in_stop;
    logic        watchdog_timeout, illegal_opcode, illegal_addr;
    logic        deepest_sleep_allowed, sys_reset, cpu_irq_req;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata;
    logic [31:0] periph_flags, en, m;
    logic [4:0]  cpu_vec_num, last;
    logic [15:0] cpu_vec_addr_hi, cpu_vec_addr_lo, fetched;
    int          errors, comparisons, i, k;

    ivl_ctrl u_dut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .irq_pin, .periph_flags,
        .software_trap, .lowv_below_lo, .lowv_below_hi, .lowv_warn_cond, .ext_reset_n,
        .watchdog_timeout, .illegal_opcode, .illegal_addr, .cpu_in_stop, .deepest_sleep_allowed,
        .sys_reset, .cpu_irq_req, .cpu_vec_num, .cpu_vec_addr_hi, .cpu_vec_addr_lo);
    ivl_cpu_model u_cpu (.clk, .rstn, .cpu_irq_req, .cpu_vec_addr_hi, .mask_clr, .fetched);

    always #10 clk = ~clk;

    function automatic logic [4:0] win(input logic [31:0] v);
        win = 5'h00;
        for (int b = 31; b >= 0; b--) if (v[b]) win = 5'(b);
    endfunction
    function automatic logic [15:0] vaddr(input logic [4:0] n);
        vaddr = 16'hFFFE - {10'h000, n, 1'b0};
    endfunction

    task automatic stop_test;
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wcyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask
    task automatic wait_rst(input logic v);
        repeat (200) begin
            #1 if (sys_reset === v) return;
            @(posedge clk);
        end
        chk("sys_reset", {15'h0000, v}, {15'h0000, sys_reset});
    endtask
    task automatic pin_to(input logic v);
        @(posedge clk) irq_pin <= v;
        wcyc(4);
    endtask

    initial begin
        #1_000_000;
        errors++;
        stop_test();
    end

    initial begin
        clk = 0; rstn = 0; wr = 0; rd = 0; addr = 0; wdata = 0; periph_flags = 0;
        {software_trap, mask_clr, lowv_below_lo, lowv_below_hi, lowv_warn_cond} = 0;
        {watchdog_timeout, illegal_opcode, illegal_addr, cpu_in_stop} = 0;
        irq_pin = 1; ext_reset_n = 1; errors = 0; comparisons = 0;
        void'($urandom(11397));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        wait_rst(1'b0);
        rd_chk(A_RST, STS_POR);
        rd_chk(A_PMC, PMC_RST);
        rd_chk(A_PIN, PIN_RST);
        wr_reg(4'hF, 8'hFF);
        rd_chk(4'hF, 8'h00);
        // pin: edge-only falling, then edge-and-level, polarity high, function off
        wr_reg(A_PIN, 8'h12);
        pin_to(1'b0);
        rd_chk(A_PIN, 8'h1A);
        rd_chk(A_VEC, 8'h82);
        wr_reg(A_PIN, 8'h16);
        rd_chk(A_PIN, 8'h12);
        wr_reg(A_PIN, 8'h13);
        wr_reg(A_PIN, 8'h17);
        rd_chk(A_PIN, 8'h1B);
        pin_to(1'b1);
        wr_reg(A_PIN, 8'h17);
        rd_chk(A_PIN, 8'h13);
        pin_to(1'b0);
        rd_chk(A_PIN, 8'h1B);
        wr_reg(A_PIN, 8'h32);
        pin_to(1'b0);
        wr_reg(A_PIN, 8'h36);
        pin_to(1'b1);
        rd_chk(A_PIN, 8'h3A);
        wr_reg(A_PIN, 8'h36);
        pin_to(1'b0);
        rd_chk(A_PIN, 8'h32);
        wr_reg(A_PIN, 8'h02);
        pin_to(1'b1);
        pin_to(1'b0);
        rd_chk(A_PIN, 8'h02);
        wr_reg(A_PIN, 8'h00);
        // peripheral priority and enables, random with two fixed corners
        last = V_PIN;
        for (i = 0; i < 24; i++) begin
            // drop requests first so enable writes cannot leave a stray winner
            @(posedge clk) begin periph_flags <= 0; software_trap <= 1'b0; end
            en = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $urandom;
            for (k = 0; k < 4; k++) wr_reg(4'(A_EN0 + k), en[8*k +: 8]);
            @(posedge clk) begin
                periph_flags <= (i < 2) ? USED : $urandom & USED;
                software_trap <= (i % 5 == 4);
            end
            wcyc(3);
            m = (periph_flags & en) | {30'h0, software_trap, 1'b0};
            if (|m) last = win(m);
            rd_chk(A_VEC, {|m, 2'b00, last});
            @(posedge clk) mask_clr <= 1'b1;
            @(posedge clk) mask_clr <= 1'b0;
            wcyc(2);
            if (|m) chk("fetched", vaddr(win(m)), fetched);
            if (|m) chk("vec_lo", vaddr(win(m)) + 16'h0001, cpu_vec_addr_lo);
        end
        @(posedge clk) begin periph_flags <= 0; software_trap <= 0; end
        for (k = 0; k < 4; k++) wr_reg(4'(A_EN0 + k), 8'h00);
        // warning flag, detect enable and stop behaviour
        wr_reg(A_PMC, 8'h24);
        @(posedge clk) lowv_warn_cond <= 1'b1;
        wcyc(4);
        rd_chk(A_PMC, 8'hA4);
        rd_chk(A_VEC, 8'h83);
        @(posedge clk) cpu_in_stop <= 1'b1;
        wr_reg(A_PMC, 8'h64);
        wcyc(4);
        rd_chk(A_PMC, 8'h24);
        // ack while still stopped: out of stop the old enables would set the flag again
        wr_reg(A_PMC, 8'h60);
        @(posedge clk) cpu_in_stop <= 1'b0;
        wcyc(4);
        rd_chk(A_PMC, 8'h20);
        @(posedge clk) lowv_warn_cond <= 1'b0;
        wr_reg(A_PMC, 8'h0C);
        #1 chk("sleep", 16'h0000, {15'h0000, deepest_sleep_allowed});
        wr_reg(A_PMC, 8'h08);
        #1 chk("sleep", 16'h0001, {15'h0000, deepest_sleep_allowed});
        // reset causes sharing slot zero
        for (k = 0; k < 4; k++) begin
            @(posedge clk) begin
                watchdog_timeout <= (k == 0);
                illegal_opcode <= (k == 1);
                illegal_addr <= (k == 2);
                ext_reset_n <= (k != 3);
            end
            if (k == 3) wcyc(2);
            @(posedge clk) begin
                {watchdog_timeout, illegal_opcode, illegal_addr} <= 3'b000;
                ext_reset_n <= 1'b1;
            end
            wait_rst(1'b1);
            wait_rst(1'b0);
            rd_chk(A_RST, 8'h01 << ((k == 3) ? S_PIN : S_WDT - k));
        end
        // low-voltage reset on each threshold, held while the supply stays low
        for (k = 0; k < 2; k++) begin
            wr_reg(A_PMC, 8'h14 | 8'(k));
            @(posedge clk) {lowv_below_hi, lowv_below_lo} <= (k == 1) ? 2'b01 : 2'b10;
            wcyc(5);
            #1 chk("sys_reset", 16'h0000, {15'h0000, sys_reset});
            @(posedge clk) {lowv_below_hi, lowv_below_lo} <= 2'b11;
            wait_rst(1'b1);
            wcyc(10);
            #1 chk("sys_reset", 16'h0001, {15'h0000, sys_reset});
            @(posedge clk) {lowv_below_hi, lowv_below_lo} <= 2'b00;
            wait_rst(1'b0);
            rd_chk(A_RST, 8'h02);
        end
        stop_test();
    end
endmodule
